// File: logic/apu_pkg.sv
package apu_pkg;
  localparam logic [7:0] DATA_PORT = 8'hc0;
  localparam logic [7:0] STAT_PORT = 8'hc1;
  localparam int BYTE_W = 8;
  localparam int STACK_BYTES = 16;
  localparam int PTR_W = 4;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
  localparam int LONG_BYTES = 4;
  localparam int SHORT_BYTES = 2;
  localparam int LONG_MSB = 31;
  localparam int SHORT_MSB = 15;
  localparam int CNT_W = 14;
  localparam logic [CNT_W-1:0] CNT_LAST = 14'h0001;
  localparam int ST_BUSY = 7;
  localparam int ST_SIGN = 6;
  localparam int ST_ZERO = 5;
  localparam int ST_ERR = 1;
  localparam int ST_CARRY = 0;
  localparam int ERR_W = 4;
  localparam logic [ERR_W-1:0] ERR_NONE = 4'h0;
  localparam logic [ERR_W-1:0] ERR_OVF = 4'h2;
  localparam logic [ERR_W-1:0] ERR_DIVZ = 4'h8;
  localparam logic [ERR_W-1:0] ERR_RANGE = 4'hc;
  localparam int CMD_SVC = 7;
  localparam int FP_EXP_SIGN = 30;
  localparam int FP_EXP_LSB = 24;
  localparam int FP_MANT_MSB = 23;
  localparam logic [6:0] EXP_ZERO = 7'h00;
  localparam logic signed [7:0] FP_EXP_MAX = 8'sh3f;
  localparam logic signed [7:0] FP_EXP_MIN = -8'sh40;
  localparam logic signed [7:0] FP_EXP_ONE = 8'sh01;
  localparam logic [23:0] FP_MANT_HALF = 24'h800000;
  localparam logic [31:0] FP_HALF_PI = 32'h01c90fdb;
  localparam logic [31:0] FP_SIGN_MASK = 32'h80000000;
  localparam logic [31:0] LONG_MIN = 32'h80000000;
  localparam logic [15:0] SHORT_MIN = 16'h8000;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;
  localparam logic [15:0] SHORT_ZERO = 16'h0000;
  localparam logic [15:0] SCR_BCD = 16'hfff0;
  localparam logic [15:0] SCR_CD = 16'hff00;
  localparam int NEG_LONG_CYC = 26;
  localparam int NEG_FLOAT_CYC = 16;
  localparam int NEG_SHORT_CYC = 22;
  localparam int ADD_LONG_CYC = 20;
  localparam int DIV_LONG_CYC = 196;
  localparam int DIV_ZERO_CYC = 18;
  localparam int COS_CYC = 3840;
  localparam int OTHER_CMD_CYC = 4;

  typedef enum logic [6:0] {
    cosine_cmd = 7'h03,
    inverse_sine_cmd = 7'h05,
    inverse_cosine_cmd = 7'h06,
    inverse_tangent_cmd = 7'h07,
    negate_float_cmd = 7'h15,
    add_long_cmd = 7'h2c,
    divide_long_cmd = 7'h2f,
    negate_long_cmd = 7'h34,
    negate_short_cmd = 7'h74
  } op_t;

  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_exec = 3'h2,
    st_done = 3'h4
  } state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } io_req_t;

  typedef struct packed {
    logic [31:0] val;
    logic carry;
    logic [ERR_W-1:0] err;
  } res_t;

  // {exponent out of range, word}; only low seven exponent bits kept, so a wrapped one is off by 128
  function automatic logic [32:0] fp_pack(logic s, logic signed [7:0] e, logic [23:0] m);
    logic ovf;
    ovf = (e > FP_EXP_MAX) || (e < FP_EXP_MIN);
    fp_pack = {ovf, (m == FP_MANT_HALF - FP_MANT_HALF) ? WORD_ZERO : {s, e[6:0], m}};
  endfunction
endpackage

// File: logic/arith_unit.sv
`timescale 1ns/100ps
module arith_unit (
  input wire apu_pkg::op_t op_i,
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  output apu_pkg::res_t res_o
);
  import apu_pkg::*;
  logic [32:0] sum;
  logic [31:0] neg_long;
  logic [15:0] neg_short;
  logic [32:0] one_fp;
  logic add_ovf;
  logic unit_mag;

  assign sum = {1'h0, a_i} + {1'h0, b_i};
  assign neg_long = WORD_ZERO - a_i;
  assign neg_short = SHORT_ZERO - a_i[SHORT_MSB:0];
  assign add_ovf = (a_i[LONG_MSB] == b_i[LONG_MSB]) && (sum[LONG_MSB] != a_i[LONG_MSB]);
  assign one_fp = fp_pack(1'h0, FP_EXP_ONE, FP_MANT_HALF);
  // magnitude at most 1.0: exponent not positive, or exactly plus or minus one
  assign unit_mag = a_i[FP_EXP_SIGN] || (a_i[FP_EXP_SIGN:FP_EXP_LSB] == EXP_ZERO) ||
                    (a_i == one_fp[31:0]) || (a_i == (one_fp[31:0] | FP_SIGN_MASK));

  always_comb begin
    res_o.val = a_i;
    res_o.carry = 1'h0;
    res_o.err = ERR_NONE;
    case (op_i)
      negate_long_cmd: begin
        if (a_i == LONG_MIN) begin
          res_o.err = ERR_OVF;
        end else begin
          res_o.val = neg_long;
        end
      end
      negate_float_cmd: begin
        if (a_i[FP_MANT_MSB]) begin
          res_o.val = a_i ^ FP_SIGN_MASK;
        end
      end
      negate_short_cmd: begin
        if (a_i[SHORT_MSB:0] == SHORT_MIN) begin
          res_o.err = ERR_OVF;
        end else begin
          res_o.val = {a_i[LONG_MSB:SHORT_MSB+1], neg_short};
        end
      end
      add_long_cmd: begin
        res_o.val = sum[LONG_MSB:0];
        res_o.carry = sum[LONG_MSB+1];
        res_o.err = add_ovf ? ERR_OVF : ERR_NONE;
      end
      inverse_cosine_cmd: begin
        res_o.val = FP_HALF_PI;
        res_o.err = unit_mag ? ERR_NONE : ERR_RANGE;
      end
      inverse_sine_cmd: begin
        res_o.err = unit_mag ? ERR_NONE : ERR_RANGE;
      end
      inverse_tangent_cmd: begin
        res_o.val = a_i;
      end
      cosine_cmd: begin
        res_o.val = one_fp[31:0];
        res_o.err = one_fp[32] ? ERR_OVF : ERR_NONE;
      end
      default: begin
        res_o.val = a_i;
      end
    endcase
  end
endmodule

// File: logic/long_divider.sv
`timescale 1ns/100ps
module long_divider #(
  parameter int W = 32
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [W-1:0] dividend_i,
  input wire logic [W-1:0] divisor_i,
  output logic [W-1:0] quo_o
);
  localparam int CW = $clog2(W) + 1;
  logic [W-1:0] rem_reg;
  logic [W-1:0] quo_reg;
  logic [W-1:0] dvs_reg;
  logic [CW-1:0] cnt_reg;
  logic neg_reg;
  logic [W:0] trial;

  // restoring division on magnitudes, one quotient bit per clock
  assign trial = {rem_reg, quo_reg[W-1]} - {1'h0, dvs_reg};

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rem_reg <= '0;
      quo_reg <= '0;
      dvs_reg <= '0;
      cnt_reg <= '0;
      neg_reg <= 1'h0;
    end else if (start_i) begin
      rem_reg <= '0;
      quo_reg <= dividend_i[W-1] ? -dividend_i : dividend_i;
      dvs_reg <= divisor_i[W-1] ? -divisor_i : divisor_i;
      neg_reg <= dividend_i[W-1] ^ divisor_i[W-1];
      cnt_reg <= CW'(W);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - CW'(1);
      if (!trial[W]) begin
        rem_reg <= trial[W-1:0];
        quo_reg <= {quo_reg[W-2:0], 1'h1};
      end else begin
        rem_reg <= {rem_reg[W-2:0], quo_reg[W-1]};
        quo_reg <= {quo_reg[W-2:0], 1'h0};
      end
    end
  end

  // integer quotient only, truncated toward zero
  assign quo_o = neg_reg ? -quo_reg : quo_reg;
endmodule

// File: logic/stack_arithmetic_processor.sv
`timescale 1ns/100ps
module stack_arithmetic_processor #(
  parameter int INVERSE_COSINE_CMD_CYC = 6304,
  parameter int INVERSE_SINE_CMD_CYC = 6230,
  parameter int INVERSE_TANGENT_CMD_CYC = 4992
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire apu_pkg::io_req_t io_i,
  output logic [7:0] rd_data_o,
  output logic busy_o,
  output logic end_exec_o,
  output logic svc_req_o
);
  import apu_pkg::*;

  logic [7:0] stack_mem [STACK_BYTES];
  logic [PTR_W-1:0] ptr_reg;
  state_t state_reg;
  state_t state_next;
  op_t op_reg;
  op_t cmd_op;
  logic svc_flag_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic sign_reg;
  logic zero_reg;
  logic carry_reg;
  logic [ERR_W-1:0] err_reg;
  logic data_sel;
  logic stat_sel;
  logic idle;
  logic done;
  logic push;
  logic pop;
  logic cmd_take;
  logic [31:0] a_val;
  logic [31:0] b_val;
  logic [31:0] quo;
  res_t alu_res;
  res_t fin;
  int wofs;
  int wlen;
  logic [STACK_BYTES-1:0] scratch;
  logic [31:0] word;
  logic short_res;
  logic [7:0] status_word;
  logic divz_reg;
  logic [STACK_BYTES-1:0] wb_hit;
  logic [7:0] wb_byte [STACK_BYTES];

  // port decode; data and command traffic is ignored while a command runs
  assign data_sel = io_i.addr == DATA_PORT;
  assign stat_sel = io_i.addr == STAT_PORT;
  assign idle = state_reg == st_idle;
  assign done = state_reg == st_done;
  assign push = io_i.wr && data_sel && idle;
  assign pop = io_i.rd && data_sel && idle;
  assign cmd_take = io_i.wr && stat_sel && idle;
  assign cmd_op = op_t'(io_i.data[CMD_SVC-1:0]);
  assign busy_o = !idle;

  // top entry a, next entry b, most significant byte nearest the top
  always_comb begin
    a_val = WORD_ZERO;
    b_val = WORD_ZERO;
    for (int k = 0; k < LONG_BYTES; k++) begin
      a_val[(LONG_BYTES - 1 - k) * BYTE_W +: BYTE_W] = stack_mem[ptr_reg - PTR_W'(k)];
      b_val[(LONG_BYTES - 1 - k) * BYTE_W +: BYTE_W] = stack_mem[ptr_reg - PTR_W'(k + LONG_BYTES)];
    end
  end

  // operand 16-bit negate works on the top two bytes
  arith_unit u_arith (
    .op_i(op_reg),
    .a_i(op_reg == negate_short_cmd ? {SHORT_ZERO, a_val[LONG_MSB:SHORT_MSB+1]} : a_val),
    .b_i(b_val),
    .res_o(alu_res)
  );

  long_divider #(
    .W(LONG_MSB + 1)
  ) u_div (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .start_i(cmd_take && cmd_op == divide_long_cmd),
    .dividend_i(b_val),
    .divisor_i(a_val),
    .quo_o(quo)
  );

  // total busy cycles per command, minus the final write-back cycle
  function automatic logic [CNT_W-1:0] exec_len(op_t op, logic divz);
    int n;
    n = OTHER_CMD_CYC;
    case (op)
      negate_long_cmd: n = NEG_LONG_CYC;
      negate_float_cmd: n = NEG_FLOAT_CYC;
      negate_short_cmd: n = NEG_SHORT_CYC;
      add_long_cmd: n = ADD_LONG_CYC;
      divide_long_cmd: n = divz ? DIV_ZERO_CYC : DIV_LONG_CYC;
      inverse_cosine_cmd: n = INVERSE_COSINE_CMD_CYC;
      inverse_sine_cmd: n = INVERSE_SINE_CMD_CYC;
      inverse_tangent_cmd: n = INVERSE_TANGENT_CMD_CYC;
      cosine_cmd: n = COS_CYC;
      default: n = OTHER_CMD_CYC;
    endcase
    exec_len = CNT_W'(n - 1);
  endfunction

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_idle: begin
        if (cmd_take) begin
          state_next = st_exec;
        end
      end
      st_exec: begin
        if (cnt_reg == CNT_LAST) begin
          state_next = st_done;
        end
      end
      st_done: begin
        state_next = st_idle;
      end
      default: begin
        state_next = st_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= st_idle;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= '0;
    end else if (cmd_take) begin
      cnt_reg <= exec_len(cmd_op, a_val == WORD_ZERO);
    end else if (state_reg == st_exec) begin
      cnt_reg <= cnt_reg - CNT_LAST;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_reg <= negate_float_cmd;
      svc_flag_reg <= 1'h0;
    end else if (cmd_take) begin
      op_reg <= cmd_op;
      svc_flag_reg <= io_i.data[CMD_SVC];
    end
  end

  // divisor test latched with the command so cycle count and result agree
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      divz_reg <= 1'h0;
    end else if (cmd_take) begin
      divz_reg <= a_val == WORD_ZERO;
    end
  end

  // divide overrides the unit: zero divisor and most negative operands
  always_comb begin
    fin = alu_res;
    if (op_reg == divide_long_cmd) begin
      if (divz_reg) begin
        fin.val = b_val;
        fin.err = ERR_DIVZ;
      end else if (a_val == LONG_MIN || b_val == LONG_MIN) begin
        fin.val = quo;
        fin.err = ERR_OVF;
      end else begin
        fin.val = quo;
      end
    end
  end

  // where the result lands, how many bytes, and which bytes serve as scratch
  always_comb begin
    wofs = 0;
    wlen = LONG_BYTES;
    scratch = '0;
    word = fin.val;
    short_res = 1'h0;
    case (op_reg)
      negate_short_cmd: begin
        wlen = SHORT_BYTES;
        word = {fin.val[SHORT_MSB:0], SHORT_ZERO};
        short_res = 1'h1;
      end
      add_long_cmd, divide_long_cmd: begin
        wofs = LONG_BYTES;
      end
      inverse_cosine_cmd, inverse_sine_cmd: begin
        scratch = SCR_BCD;
      end
      inverse_tangent_cmd, cosine_cmd: begin
        scratch = SCR_CD;
      end
      negate_long_cmd, negate_float_cmd: begin
        wofs = 0;
      end
      default: begin
        wlen = 0;
      end
    endcase
  end

  // per depth below the top: is it a result byte, and which one
  for (genvar g = 0; g < STACK_BYTES; g++) begin : g_wb
    int rel;
    logic [$clog2(LONG_BYTES)-1:0] sel;
    assign rel = g - wofs;
    assign sel = rel[$clog2(LONG_BYTES)-1:0];
    assign wb_hit[g] = (rel >= 0) && (rel < wlen);
    assign wb_byte[g] = word[(LONG_BYTES - 1 - int'(sel)) * BYTE_W +: BYTE_W];
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int k = 0; k < STACK_BYTES; k++) begin
        stack_mem[k] <= 8'h00;
      end
    end else if (push) begin
      stack_mem[ptr_reg + PTR_ONE] <= io_i.data;
    end else if (done) begin
      for (int k = 0; k < STACK_BYTES; k++) begin
        if (wb_hit[k]) begin
          stack_mem[ptr_reg - PTR_W'(k)] <= wb_byte[k];
        end else if (scratch[k]) begin
          stack_mem[ptr_reg - PTR_W'(k)] <= 8'h00;
        end
      end
    end
  end

  // circular pointer; reading a byte pops it
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_reg <= '0;
    end else if (push) begin
      ptr_reg <= ptr_reg + PTR_ONE;
    end else if (pop) begin
      ptr_reg <= ptr_reg - PTR_ONE;
    end else if (done) begin
      ptr_reg <= ptr_reg - PTR_W'(wofs);
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sign_reg <= 1'h0;
      zero_reg <= 1'h0;
    end else if (done) begin
      if (short_res) begin
        sign_reg <= fin.val[SHORT_MSB];
        zero_reg <= fin.val[SHORT_MSB:0] == SHORT_ZERO;
      end else begin
        sign_reg <= fin.val[LONG_MSB];
        zero_reg <= fin.val == WORD_ZERO;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      carry_reg <= 1'h0;
      err_reg <= ERR_NONE;
    end else if (done) begin
      carry_reg <= fin.carry;
      err_reg <= fin.err;
    end
  end

  always_comb begin
    status_word = 8'h00;
    status_word[ST_BUSY] = busy_o;
    status_word[ST_SIGN] = sign_reg;
    status_word[ST_ZERO] = zero_reg;
    status_word[ST_ERR +: ERR_W] = err_reg;
    status_word[ST_CARRY] = carry_reg;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= 8'h00;
    end else if (io_i.rd) begin
      if (stat_sel) begin
        rd_data_o <= status_word;
      end else if (data_sel && idle) begin
        rd_data_o <= stack_mem[ptr_reg];
      end else begin
        rd_data_o <= 8'h00;
      end
    end
  end

  // end pulse coincides with busy dropping
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      end_exec_o <= 1'h0;
    end else begin
      end_exec_o <= done;
    end
  end

  // service request raised at completion, held until the next command is taken
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      svc_req_o <= 1'h0;
    end else if (done && svc_flag_reg) begin
      svc_req_o <= 1'h1;
    end else if (cmd_take) begin
      svc_req_o <= 1'h0;
    end
  end
endmodule

// File: tb/io_host_model.sv
`timescale 1ns/100ps
module io_host_model
  import apu_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic [7:0] rd_data_i,
  input wire logic busy_i,
  input wire logic end_exec_i,
  output apu_pkg::io_req_t io_o
);
  initial io_o = '0;

  // one strobe cycle; released lines flip so stale values are never trusted
  task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    io_o <= '{rd: rd, wr: !rd, addr: a, data: d};
    @(negedge core_clk_i);
    io_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~d};
  endtask

  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    bus(1'b1, a, 8'h00);
    d = rd_data_i;
  endtask

  task automatic push32(input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, DATA_PORT, v[8*i +: 8]);
    end
  endtask

  task automatic pop32(output logic [31:0] v);
    logic [7:0] b;
    for (int i = 3; i >= 0; i--) begin
      rd_byte(DATA_PORT, b);
      v[8*i +: 8] = b;
    end
  endtask

  // the host polls busy and counts its cycles
  task automatic run(input logic [7:0] cmd, output int n, output logic ended);
    bus(1'b0, STAT_PORT, cmd);
    n = 0;
    while (busy_i === 1'b1 && n < 10000) begin
      n++;
      @(negedge core_clk_i);
    end
    ended = end_exec_i;
  endtask
endmodule

// File: tb/sap_checker_assertions.sv
`timescale 1ns/100ps
module sap_checker
  import apu_pkg::*;
#(
  parameter int INVERSE_COSINE_CMD_CYC = 6304,
  parameter int INVERSE_SINE_CMD_CYC = 6230,
  parameter int INVERSE_TANGENT_CMD_CYC = 4992
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire apu_pkg::io_req_t io_i,
  input wire logic [7:0] rd_data_o,
  input wire logic busy_o,
  input wire logic end_exec_o,
  input wire logic svc_req_o
);
  logic [13:0] busy_cnt;
  logic cmd_take;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  assign cmd_take = io_i.wr && io_i.addr == STAT_PORT && !busy_o;

  // busy cycles of the command now running
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_cnt <= 14'h0000;
    end else if (busy_o) begin
      busy_cnt <= busy_cnt + 14'h0001;
    end else begin
      busy_cnt <= 14'h0000;
    end
  end

  property p_end_after_busy;
    end_exec_o |-> $past(busy_o) && !busy_o;
  endproperty
  a_end_after_busy: assert property (p_end_after_busy) else $error("end pulse without busy fall");

  property p_fall_gives_end;
    $fell(busy_o) |-> end_exec_o;
  endproperty
  a_fall_gives_end: assert property (p_fall_gives_end) else $error("busy fell without end pulse");

  property p_cmd_starts;
    cmd_take |=> busy_o;
  endproperty
  a_cmd_starts: assert property (p_cmd_starts) else $error("command not started");

  property p_busy_min;
    $rose(busy_o) |-> busy_o [*4];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");

  property p_busy_len;
    $fell(busy_o) |-> busy_cnt inside {OTHER_CMD_CYC, NEG_FLOAT_CYC, DIV_ZERO_CYC, ADD_LONG_CYC, NEG_SHORT_CYC,
                                       NEG_LONG_CYC, DIV_LONG_CYC, COS_CYC, INVERSE_COSINE_CMD_CYC, INVERSE_SINE_CMD_CYC, INVERSE_TANGENT_CMD_CYC};
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length not a known time");

  property p_svc_hold;
    svc_req_o && !cmd_take |=> svc_req_o;
  endproperty
  a_svc_hold: assert property (p_svc_hold) else $error("service request dropped");

  property p_svc_clear;
    cmd_take |=> !svc_req_o;
  endproperty
  a_svc_clear: assert property (p_svc_clear) else $error("service request kept");

  property p_svc_rise;
    $rose(svc_req_o) |-> end_exec_o;
  endproperty
  a_svc_rise: assert property (p_svc_rise) else $error("service request off completion");

  property p_status_busy;
    io_i.rd && io_i.addr == STAT_PORT |=> rd_data_o[ST_BUSY] == $past(busy_o);
  endproperty
  a_status_busy: assert property (p_status_busy) else $error("status busy bit wrong");

  property p_rd_hold;
    !io_i.rd |=> $stable(rd_data_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

  property p_unmapped;
    io_i.rd && io_i.addr != STAT_PORT && io_i.addr != DATA_PORT |=> rd_data_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  c_done: cover property ($fell(busy_o));
  c_svc: cover property ($rose(svc_req_o));
  c_div: cover property ($fell(busy_o) && busy_cnt == 14'(DIV_LONG_CYC));
endmodule

bind stack_arithmetic_processor sap_checker #(.INVERSE_COSINE_CMD_CYC(INVERSE_COSINE_CMD_CYC), .INVERSE_SINE_CMD_CYC(INVERSE_SINE_CMD_CYC), .INVERSE_TANGENT_CMD_CYC(INVERSE_TANGENT_CMD_CYC)) i_chk (
  .core_clk_i(core_clk_i),
  .nrst_i(nrst_i),
  .io_i(io_i),
  .rd_data_o(rd_data_o),
  .busy_o(busy_o),
  .end_exec_o(end_exec_o),
  .svc_req_o(svc_req_o)
);

// File: tb/stack_arithmetic_processor_tb.sv
`timescale 1ns/100ps
module stack_arithmetic_processor_tb;
  import apu_pkg::*;
  localparam int TR_CYC = 8;
  logic core_clk_i;
  logic nrst_i;
  io_req_t io;
  logic [7:0] rd_data;
  logic busy;
  logic end_exec;
  logic svc_req;
  int failures = 0;
  int n_tests = 0;

  stack_arithmetic_processor #(.INVERSE_COSINE_CMD_CYC(TR_CYC), .INVERSE_SINE_CMD_CYC(TR_CYC), .INVERSE_TANGENT_CMD_CYC(TR_CYC)) i_dut (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .io_i(io),
    .rd_data_o(rd_data),
    .busy_o(busy),
    .end_exec_o(end_exec),
    .svc_req_o(svc_req)
  );

  io_host_model i_host (
    .core_clk_i(core_clk_i),
    .rd_data_i(rd_data),
    .busy_i(busy),
    .end_exec_i(end_exec),
    .io_o(io)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic t_reset;
    logic [7:0] s;
    i_host.rd_byte(STAT_PORT, s);
    check(s, 8'h00);
    i_host.rd_byte(8'h10, s);
    check(s, 8'h00);
  endtask

  // push b then a, run, judge cycles, status and what the stack gives back
  task automatic op(input logic [31:0] b, input logic [31:0] a, input logic [7:0] cmd, input logic [31:0] r,
                    input logic [7:0] st, input int n, input logic unary);
    int cyc;
    logic ended;
    logic [7:0] s;
    logic [31:0] v;
    i_host.push32(b);
    i_host.push32(a);
    i_host.run(cmd, cyc, ended);
    check(cyc, n);
    check(ended, 1'b1);
    i_host.rd_byte(STAT_PORT, s);
    check(s, st);
    i_host.pop32(v);
    check(v, r);
    if (unary) begin
      i_host.pop32(v);
      check(v, b);
    end
  endtask

  task automatic t_fixed;
    op(32'h00000003, 32'hffffffff, 8'h2c, 32'h00000002, 8'h01, ADD_LONG_CYC, 1'b0);
    op(32'h7fffffff, 32'h00000001, 8'hac, LONG_MIN, 8'h44, ADD_LONG_CYC, 1'b0);
    op(32'h00000064, 32'h00000007, 8'h2f, 32'h0000000e, 8'h00, DIV_LONG_CYC, 1'b0);
    op(32'hffffff9c, 32'h00000007, 8'h2f, 32'hfffffff2, 8'h40, DIV_LONG_CYC, 1'b0);
    op(32'h00000064, WORD_ZERO, 8'h2f, 32'h00000064, 8'h10, DIV_ZERO_CYC, 1'b0);
    op(32'h12345678, 32'h00000005, 8'h34, 32'hfffffffb, 8'h40, NEG_LONG_CYC, 1'b1);
    op(32'h12345678, LONG_MIN, 8'hb4, LONG_MIN, 8'h44, NEG_LONG_CYC, 1'b1);
    op(32'h12345678, 32'h00051234, 8'h74, 32'hfffb1234, 8'h40, NEG_SHORT_CYC, 1'b1);
    op(32'h12345678, 32'h80001234, 8'hf4, 32'h80001234, 8'h44, NEG_SHORT_CYC, 1'b1);
  endtask

  task automatic t_float;
    op(32'h12345678, 32'h01800000, 8'h15, 32'h81800000, 8'h40, NEG_FLOAT_CYC, 1'b1);
    op(32'h12345678, WORD_ZERO, 8'h95, WORD_ZERO, 8'h20, NEG_FLOAT_CYC, 1'b1);
  endtask

  // arguments beyond unit magnitude, service request flag set then cleared
  task automatic t_trans;
    logic [7:0] cmds [3] = '{8'h86, 8'h05, 8'h87};
    logic [3:0] errs [3] = '{4'hc, 4'hc, 4'h0};
    int cyc;
    logic ended;
    logic [7:0] s;
    for (int i = 0; i < 3; i++) begin
      i_host.push32(32'h01800000);
      i_host.push32(32'h02800000);
      i_host.run(cmds[i], cyc, ended);
      check(cyc, TR_CYC);
      i_host.rd_byte(STAT_PORT, s);
      check(s[4:1], errs[i]);
      check(svc_req, cmds[i][CMD_SVC]);
    end
  endtask

  // in-range arguments, results, and which entries are lost as scratch
  task automatic t_arc;
    int cyc;
    logic ended;
    logic [7:0] s;
    logic [31:0] v;
    i_host.push32(32'h12345678);
    i_host.push32(32'h01800000);
    i_host.run(8'h06, cyc, ended);
    check(cyc, TR_CYC);
    i_host.rd_byte(STAT_PORT, s);
    check(s, 8'h00);
    i_host.pop32(v);
    check(v, FP_HALF_PI);
    i_host.pop32(v);
    check(v, WORD_ZERO);
    i_host.push32(32'h0a0b0c0d);
    i_host.push32(32'h12345678);
    i_host.push32(32'h02800000);
    i_host.run(8'h07, cyc, ended);
    check(ended, 1'b1);
    i_host.rd_byte(STAT_PORT, s);
    check(s, 8'h00);
    i_host.pop32(v);
    check(v, 32'h02800000);
    i_host.pop32(v);
    check(v, 32'h12345678);
    i_host.pop32(v);
    check(v, WORD_ZERO);
    op(32'h12345678, 32'h80800000, 8'h85, 32'h80800000, 8'h40, TR_CYC, 1'b0);
    op(32'h12345678, 32'h02800000, 8'h83, 32'h01800000, 8'h00, COS_CYC, 1'b1);
    op(32'h12345678, 32'h80000005, 8'h00, 32'h80000005, 8'h40, OTHER_CMD_CYC, 1'b1);
  endtask

  initial begin
    nrst_i = 1'b0;
    repeat (12) @(posedge core_clk_i);
    @(negedge core_clk_i);
    nrst_i = 1'b1;
    t_reset();
    t_fixed();
    t_float();
    t_trans();
    t_arc();
    summarize();
  end

  initial begin
    #200000;
    failures++;
    summarize();
  end
endmodule
